// >>> hdl/bsd_map.svh
// Constants for the boot strap capture and register window decoder.
// Assumes inclusion by bare name from the package and the top module.
//
// Contract
// [RQ1] Sample data pins 15..8 as boot byte
// [RQ2] Data pin 7 sets core timer interrupts
// [RQ3] Data pin 5 picks lane strobe role
// [RQ4] Data pin 4 sets channel-0 wait bit
// [RQ5] Data pin 2 picks PCI arbiter
// [RQ6] Data pins 1..0 give boot bus width
// [RQ7] Board holds straps stable; reserved ignored
// [RQ8] Decode a 36-bit physical address space
// [RQ9] After reset only window and vectors map
// [RQ10] Vectors from channel 0 or PCI
// [RQ11] 64 KB window at fixed and relocated base
// [RQ12] Both windows reach the same register
// [RQ13] 32-bit registers take 32-bit transfers only
// [RQ14] 64-bit registers take 64 or two 32
// [RQ15] Big endian offset 0 picks upper half
// [RQ16] Satellite config cycles: any size, little endian
// [RQ17] Address pin 12 strap sets endian mode
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH

// ---------------------------------------------------------------
// Strap bit positions on the data pins
// ---------------------------------------------------------------
`define BSD_BOOT_BYTE_HI 15
`define BSD_BOOT_BYTE_LO 8
`define BSD_TIMER_BIT 7
`define BSD_LANE_BIT 5
`define BSD_WAIT_BIT 4
`define BSD_ARB_BIT 2
`define BSD_WIDTH_HI 1
`define BSD_WIDTH_LO 0

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define BSD_PADDR_W 36
`define BSD_WIN_W 16
`define BSD_WIN_BASE 36'hf_ff1f_0000
`define BSD_VEC_BASE 36'hf_1fc0_0000
`define BSD_VEC_SPAN_W 22
`define BSD_HALF_BIT 2

// ---------------------------------------------------------------
// Reset values of captured fields
// ---------------------------------------------------------------
`define BSD_RST_BOOT_BYTE 8'h00
`define BSD_RST_WIDTH 2'h1

`endif

// >>> hdl/bsd_pkg.sv
// Types for the boot strap capture and register window decoder.
// Assumes the constants header is on the include path.
`include "bsd_map.svh"

package bsd_pkg;

  // Boot bus width code as the straps present it
  typedef enum logic [1:0] {
    BSD_W_RSVD = 2'h0,
    BSD_W_32 = 2'h1,
    BSD_W_16 = 2'h2,
    BSD_W_8 = 2'h3
  } bsd_width_t;

  // Transfer size of a register access
  typedef enum logic [1:0] {
    BSD_SZ_OTHER = 2'h0,
    BSD_SZ_32 = 2'h1,
    BSD_SZ_64 = 2'h2
  } bsd_size_t;

  // Configuration captured at reset release
  typedef struct packed {
    logic [7:0] boot_cfg_byte;
    logic core_timer_irq_off;
    logic lane_strobe_select;
    logic wait_mode_field;
    logic pci_arbiter_choice;
    bsd_width_t boot_width_field;
    logic big_endian;
  } bsd_strap_t;

  // One processor or PCI access request
  typedef struct packed {
    logic valid;
    logic [`BSD_PADDR_W-1:0] addr;
    bsd_size_t size;
    logic reg_wide;
    logic pci_cfg;
  } bsd_req_t;

  // Decode answer
  typedef struct packed {
    logic valid;
    logic win_hit;
    logic via_reloc;
    logic [`BSD_WIN_W-1:0] offset;
    logic lane_hi;
    logic lane_lo;
    logic size_bad;
    logic cfg_ok;
    logic little_endian;
    logic vec_ch0;
    logic vec_pci;
    logic unmapped;
  } bsd_ans_t;

endpackage

// >>> hdl/bsd_top.sv
// Boot strap capture and internal register window decoder.
// Assumes straps stay stable on the pins around reset release and that
// request fields come from logic on clk.
`timescale 1ns/10ps
`default_nettype none
`include "bsd_map.svh"

module bsd_top
  import bsd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] data_pin,
  input wire logic addr12_pin,
  input wire logic [`BSD_PADDR_W-1:`BSD_WIN_W] reloc_base,
  input wire logic boot_from_pci,
  input wire logic satellite_mode,
  input wire bsd_req_t req,
  output bsd_strap_t strap_r,
  output logic strap_done_r,
  output bsd_ans_t ans_r
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [16:0] pin_meta_r;
  logic [16:0] pin_sync_r;

  // Free running, so the level is settled by the time reset lifts
  always_ff @(posedge clk) begin
    pin_meta_r <= {addr12_pin, data_pin};
    pin_sync_r <= pin_meta_r;
  end

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic [15:0] dsync;
  assign dsync = pin_sync_r[15:0];

  // First edge after release; board keeps levels steady (see [RQ7])
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // Reserved positions 6 and 3 are never read (see [RQ7])
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_r.boot_cfg_byte <= `BSD_RST_BOOT_BYTE;
      strap_r.core_timer_irq_off <= 1'b0;
      strap_r.lane_strobe_select <= 1'b0;
      strap_r.wait_mode_field <= 1'b0;
      strap_r.pci_arbiter_choice <= 1'b0;
      strap_r.boot_width_field <= bsd_width_t'(`BSD_RST_WIDTH);
      strap_r.big_endian <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r.boot_cfg_byte <=
        dsync[`BSD_BOOT_BYTE_HI:`BSD_BOOT_BYTE_LO]; // see [RQ1]
      // High level disables core timer interrupts
      strap_r.core_timer_irq_off <= dsync[`BSD_TIMER_BIT]; // see [RQ2]
      strap_r.lane_strobe_select <= dsync[`BSD_LANE_BIT]; // see [RQ3]
      strap_r.wait_mode_field <= dsync[`BSD_WAIT_BIT]; // see [RQ4]
      strap_r.pci_arbiter_choice <= dsync[`BSD_ARB_BIT]; // see [RQ5]
      strap_r.boot_width_field <=
        bsd_width_t'(dsync[`BSD_WIDTH_HI:`BSD_WIDTH_LO]); // see [RQ6]
      strap_r.big_endian <= pin_sync_r[16]; // see [RQ17]
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  localparam logic [`BSD_PADDR_W-1:0] WIN_BASE = `BSD_WIN_BASE;
  localparam logic [`BSD_PADDR_W-1:0] VEC_BASE = `BSD_VEC_BASE;
  logic fix_hit;
  logic rel_hit;
  logic win_nxt;
  logic vec_hit;
  logic half_sel;
  logic upper_nxt;

  // Upper 20-bit compare, bits 35..16, on both bases (see [RQ8], [RQ11])
  assign fix_hit = req.addr[`BSD_PADDR_W-1:`BSD_WIN_W] ==
                   WIN_BASE[`BSD_PADDR_W-1:`BSD_WIN_W];
  assign rel_hit = req.addr[`BSD_PADDR_W-1:`BSD_WIN_W] == reloc_base;
  assign win_nxt = fix_hit | rel_hit;
  // Vector region is the only other mapping at start-up (see [RQ9])
  assign vec_hit = req.addr[`BSD_PADDR_W-1:`BSD_VEC_SPAN_W] ==
                   VEC_BASE[`BSD_PADDR_W-1:`BSD_VEC_SPAN_W];
  assign half_sel = req.addr[`BSD_HALF_BIT];
  // Big endian: offset 0 is the upper word; little reverses (see [RQ15])
  assign upper_nxt = strap_r.big_endian ? !half_sel : half_sel;

  // Answer register, one cycle after the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ans_r <= '0;
    end else begin
      ans_r.valid <= req.valid;
      ans_r.win_hit <= req.valid & win_nxt & !req.pci_cfg;
      ans_r.via_reloc <= req.valid & rel_hit & !fix_hit;
      // Offset alone selects the register, whichever base (see [RQ12])
      ans_r.offset <= req.addr[`BSD_WIN_W-1:0];
      // Wide register: 64-bit gives both halves (see [RQ14])
      ans_r.lane_hi <= req.valid & win_nxt & (req.size == BSD_SZ_64 ||
        (req.size == BSD_SZ_32 && (!req.reg_wide || upper_nxt)));
      ans_r.lane_lo <= req.valid & win_nxt & (req.size == BSD_SZ_64 ||
        (req.size == BSD_SZ_32 && req.reg_wide && !upper_nxt));
      // Narrow register refuses all but 32-bit (see [RQ13])
      ans_r.size_bad <= req.valid & win_nxt & !req.pci_cfg &
        (req.reg_wide ? req.size == BSD_SZ_OTHER : req.size != BSD_SZ_32);
      // Config cycles only in satellite mode, any size (see [RQ16])
      ans_r.cfg_ok <= req.valid & req.pci_cfg & satellite_mode;
      ans_r.little_endian <= req.pci_cfg | !strap_r.big_endian;
      // Vector fetch goes to channel 0 or to PCI (see [RQ10])
      ans_r.vec_ch0 <= req.valid & vec_hit & !win_nxt & !boot_from_pci;
      ans_r.vec_pci <= req.valid & vec_hit & !win_nxt & boot_from_pci;
      ans_r.unmapped <= req.valid & !req.pci_cfg & !win_nxt & !vec_hit;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_strap_boot_byte: assert property ( // see [RQ1]
    $rose(strap_done_r) |-> strap_r.boot_cfg_byte ==
      $past(dsync[`BSD_BOOT_BYTE_HI:`BSD_BOOT_BYTE_LO]))
    else $error("boot byte not taken from pins");

  chk_strap_timer_lane: assert property ( // see [RQ2] [RQ3]
    $rose(strap_done_r) |->
      strap_r.core_timer_irq_off == $past(dsync[`BSD_TIMER_BIT]) &&
      strap_r.lane_strobe_select == $past(dsync[`BSD_LANE_BIT]))
    else $error("timer or lane strap wrong");

  chk_strap_wait_arb: assert property ( // see [RQ4] [RQ5]
    $rose(strap_done_r) |->
      strap_r.wait_mode_field == $past(dsync[`BSD_WAIT_BIT]) &&
      strap_r.pci_arbiter_choice == $past(dsync[`BSD_ARB_BIT]))
    else $error("wait or arbiter strap wrong");

  chk_strap_width_endian: assert property ( // see [RQ6] [RQ17]
    $rose(strap_done_r) |->
      strap_r.boot_width_field == $past(dsync[`BSD_WIDTH_HI:`BSD_WIDTH_LO]) &&
      strap_r.big_endian == $past(pin_sync_r[16]))
    else $error("width or endian strap wrong");

  chk_strap_hold: assert property ( // see [RQ7]
    strap_done_r && $past(strap_done_r) |-> $stable(strap_r))
    else $error("straps changed after capture");

  chk_window_alias: assert property ( // see [RQ12]
    req.valid && win_nxt && !req.pci_cfg |=>
      ans_r.win_hit && ans_r.offset == $past(req.addr[15:0]))
    else $error("window hit or offset lost");

  chk_half_select: assert property ( // see [RQ15]
    req.valid && win_nxt && req.reg_wide && req.size == BSD_SZ_32 |=>
      ans_r.lane_hi == ($past(strap_r.big_endian) ^ $past(half_sel)) &&
      ans_r.lane_lo != ans_r.lane_hi)
    else $error("wrong half for 32-bit access");

  chk_narrow_size: assert property ( // see [RQ13]
    req.valid && win_nxt && !req.pci_cfg && !req.reg_wide &&
      req.size != BSD_SZ_32 |=> ans_r.size_bad)
    else $error("bad size on narrow register not flagged");

  chk_cfg_little: assert property ( // see [RQ16]
    req.valid && req.pci_cfg && satellite_mode |=>
      ans_r.cfg_ok && ans_r.little_endian && !ans_r.size_bad)
    else $error("satellite config access mishandled");

  chk_unmapped_only: assert property ( // see [RQ9]
    ans_r.unmapped |-> !ans_r.win_hit && !ans_r.vec_ch0 && !ans_r.vec_pci)
    else $error("unmapped flagged with a hit");

  // Upper bits all count, so an alias 32 GB away must miss
  chk_fixed_base: assert property ( // see [RQ8]
    req.valid && !req.pci_cfg && req.addr[`BSD_PADDR_W-1:`BSD_WIN_W] ==
      WIN_BASE[`BSD_PADDR_W-1:`BSD_WIN_W] |=>
      ans_r.win_hit && !ans_r.via_reloc && !ans_r.unmapped)
    else $error("fixed window base not decoded");

  chk_reloc_base: assert property ( // see [RQ11]
    req.valid && !req.pci_cfg &&
      req.addr[`BSD_PADDR_W-1:`BSD_WIN_W] == reloc_base |=>
      ans_r.win_hit && !ans_r.unmapped)
    else $error("relocated window base not decoded");

  chk_wide_both: assert property ( // see [RQ14]
    req.valid && win_nxt && !req.pci_cfg && req.reg_wide &&
      req.size == BSD_SZ_64 |=>
      ans_r.lane_hi && ans_r.lane_lo && !ans_r.size_bad)
    else $error("64-bit access to wide register mishandled");

  // Exactly one boot source answers a vector fetch
  chk_vector_route: assert property ( // see [RQ10]
    req.valid && !req.pci_cfg && !win_nxt && vec_hit |=>
      ans_r.vec_pci == $past(boot_from_pci) &&
      ans_r.vec_ch0 == !$past(boot_from_pci))
    else $error("vector fetch sent to wrong bus");

  chk_endian_strap: assert property ( // see [RQ17]
    req.valid && !req.pci_cfg |=>
      ans_r.little_endian == !$past(strap_r.big_endian))
    else $error("register endian does not follow strap");

  cov_reloc_hit: cover property (req.valid && rel_hit && !fix_hit ##1
    ans_r.win_hit);
  cov_two_halves: cover property (ans_r.lane_hi && !ans_r.lane_lo ##1
    ans_r.lane_lo && !ans_r.lane_hi);
  cov_pci_vector: cover property (ans_r.vec_pci);
  cov_cfg_cycle: cover property (ans_r.cfg_ok);
  cov_size_refused: cover property (ans_r.size_bad);

endmodule

`default_nettype wire

// >>> verification/bsd_board_model.sv
// Board strap model: resistors that set the data and address pin levels.
// The bench sets the pattern while reset is held low and inverts it once after capture.
`timescale 1ns/10ps
`default_nettype none
module bsd_board_model (
  input wire logic [15:0] pattern,
  input wire logic big_end,
  output logic [15:0] data_pin,
  output logic addr12_pin
);
  // Reserved positions 6 and 3 are tied low and mean nothing
  assign data_pin = pattern & 16'hffb7;
  assign addr12_pin = big_end; // Endian strap level
endmodule
`default_nettype wire

// >>> verification/tb_bsd_top.sv
// Bench for the strap capture and register window decoder.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "bsd_map.svh"
module tb_bsd_top;
  import bsd_pkg::*;
  logic clk = 0, resetn = 0, boot_from_pci = 0, satellite_mode = 1;
  logic big_end = 0, addr12_pin, strap_done_r;
  logic [15:0] pattern = 16'h0000, data_pin;
  logic [`BSD_PADDR_W-1:`BSD_WIN_W] reloc_base = 20'h12345;
  logic [15:0] pats [4] = '{16'ha5f1, 16'h5a0e, 16'hc3b3, 16'h3c40};
  logic [9:0] m = 10'h3ff, l = 10'h33f;
  bsd_req_t req = '0;
  bsd_strap_t strap_r;
  bsd_ans_t ans_r;
  int num_errors = 0, checks_done = 0;
  always #20 clk = ~clk;
  bsd_board_model bsd_board_model_inst (.pattern(pattern),
    .big_end(big_end), .data_pin(data_pin), .addr12_pin(addr12_pin));
  bsd_top bsd_top_inst (.clk(clk), .resetn(resetn), .data_pin(data_pin),
    .addr12_pin(addr12_pin), .reloc_base(reloc_base),
    .boot_from_pci(boot_from_pci), .satellite_mode(satellite_mode),
    .req(req), .strap_r(strap_r), .strap_done_r(strap_done_r),
    .ans_r(ans_r));
  // Shared comparison, counts every check
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Straps are set while reset is low so they are steady at release
  task automatic do_reset(input logic [15:0] p, input logic e);
    @(posedge clk);
    #1;
    resetn = 0;
    pattern = p;
    big_end = e;
    repeat (10) @(posedge clk);
    #1;
    chk(strap_r === {`BSD_RST_BOOT_BYTE, 4'h0, `BSD_RST_WIDTH, 1'b0} &&
      strap_done_r === 1'b0, "reset straps");
    chk(ans_r === '0, "reset answer");
    resetn = 1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // One request, answer one cycle later; lanes of wide 32 worked out here
  task automatic acc(input logic [35:0] a, input bsd_size_t sz,
      input logic w, input logic c, input logic [9:0] ex,
      input logic [9:0] mk);
    logic [9:0] got;
    req = '{1'b1, a, sz, w, c};
    @(posedge clk);
    #1;
    if (ex[9] && w && sz == BSD_SZ_32)
      ex[7:6] = {big_end ^ a[2], ~(big_end ^ a[2])};
    ex[3] = c | ~big_end;
    got = {ans_r.win_hit, ans_r.via_reloc, ans_r.lane_hi, ans_r.lane_lo,
      ans_r.size_bad, ans_r.cfg_ok, ans_r.little_endian, ans_r.vec_ch0,
      ans_r.vec_pci, ans_r.unmapped};
    chk(ans_r.valid === 1'b1 && (got & mk) === (ex & mk), "decode");
    if (ex[9]) chk(ans_r.offset === a[15:0], "window offset");
  endtask
  // Back-to-back requests over window, vectors, holes and config cycles
  task automatic run_decode();
    acc(36'hf_ff1f_8004, BSD_SZ_32, 1, 0, 10'h200, m);
    acc(36'hf_ff1f_8000, BSD_SZ_32, 1, 0, 10'h200, m);
    acc(36'h1_2345_8000, BSD_SZ_32, 1, 0, 10'h300, m);
    acc(36'h1_2345_9008, BSD_SZ_64, 1, 0, 10'h3c0, m);
    acc(36'hf_ff1f_d000, BSD_SZ_64, 0, 0, 10'h220, l);
    acc(36'hf_ff1f_d004, BSD_SZ_32, 0, 0, 10'h280, m);
    acc(36'hf_ff1f_9000, BSD_SZ_OTHER, 1, 0, 10'h220, l);
    acc(36'hf_1fc0_0100, BSD_SZ_32, 0, 0, 10'h004, l);
    acc(36'h7_ff1f_8000, BSD_SZ_32, 0, 0, 10'h001, l);
    acc(36'h0_0000_0010, BSD_SZ_OTHER, 0, 1, 10'h010, l);
    boot_from_pci = 1;
    satellite_mode = 0;
    acc(36'hf_1fc0_0100, BSD_SZ_32, 0, 0, 10'h002, l);
    acc(36'h0_0000_0010, BSD_SZ_OTHER, 0, 1, 10'h000, 10'h337);
    boot_from_pci = 0;
    satellite_mode = 1;
    req.valid = 0;
    @(posedge clk);
    #1;
    chk(ans_r.valid === 1'b0, "answer lasts one cycle");
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    chk(1'b0, "timeout");
    final_report();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(pats[i], i[0]);
      chk(strap_done_r === 1'b1, "capture done");
      chk(strap_r.boot_cfg_byte === pats[i][15:8], "boot byte");
      chk(strap_r.core_timer_irq_off === pats[i][7], "timer");
      chk(strap_r.lane_strobe_select === pats[i][5], "lanes");
      chk(strap_r.wait_mode_field === pats[i][4], "wait");
      chk(strap_r.pci_arbiter_choice === pats[i][2], "arbiter");
      chk(strap_r.boot_width_field === pats[i][1:0], "width");
      chk(strap_r.big_endian === i[0], "endian");
      // Pins moving after capture must be ignored
      pattern = ~pattern;
      repeat (3) @(posedge clk);
      #1;
      chk(strap_r.boot_cfg_byte === pats[i][15:8], "held");
      run_decode();
      $display("Test %0d done", i);
    end
    final_report();
  end
endmodule
`default_nettype wire
